/* design/i2c_port_defs.vh */
// Purpose: Constants for the regulator I2C slave port
// Assumes: Included by the port module only
// Notes:   Offsets are register indices on the serial link, byte address is four times index
`ifndef I2C_PORT_DEFS_VH
`define I2C_PORT_DEFS_VH
// ---------------------------------------------------------------------------
// Serial link
// ---------------------------------------------------------------------------
`define SLAVE_ADDR        7'h60
`define MASTER_CODE_TOP   5'h01
`define NUM_REGS          8
// ---------------------------------------------------------------------------
// Serial register indices
// ---------------------------------------------------------------------------
`define IDX_PULLDOWN      3'h0
`define IDX_PULLDOWN_BIT_EN  0
`define IDX_PULLDOWN_BIT_SEL 1
`define REG_DEFAULT       8'h00
// ---------------------------------------------------------------------------
// Avalon-MM word addresses
// ---------------------------------------------------------------------------
`define AV_REG_BASE       4'h0
`define AV_STATUS         4'h8
`define AV_CONTROL        4'h9
`define AV_BAD_DATA       32'hDEADBEEF
`endif

/* design/regulator_i2c_slave_port.v */
// Purpose: I2C slave front end with register file and pin pull-down control
// Assumes: CLK_SYS 10 MHz oversamples SCL and SDA through three-flop filters
// Notes:   Avalon-MM slave mirrors registers; supply lockout acts as reset
//          Link inputs lag about four clocks behind the pins through the filters,
//          so the bus master must keep SCL low at least six clocks in each bit.
//          Avalon reads stall one cycle so that read data comes from flip-flops.
//          Avalon writes stall one cycle only when a link commit lands.
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_defs.vh"
module regulator_i2c_slave_port (
  input  wire        CLK_SYS,          // System clock, 10 MHz
  input  wire        RST,              // Synchronous reset, active high
  input  wire        SUPPLY_LOCKOUT,   // Logic supply below lockout level
  input  wire        SCL_IN,           // Serial clock level
  input  wire        SDA_IN,           // Serial data level
  output reg         SDA_OUT,          // Serial data drive value, always low
  output reg         SDA_OE,           // High while pulling SDA low
  input  wire        ENABLE_PIN,       // Enable input level
  input  wire        VOLTAGE_SELECT_PIN, // Voltage-select input level
  output reg         ENABLE_PD_ON,     // Pull-down on enable pin connected
  output reg         SELECT_PD_ON,     // Pull-down on select pin connected
  output reg         HS_MODE,          // High-speed mode active
  input  wire [3:0]  AVS_ADDRESS,      // Word address
  input  wire        AVS_READ,         // Read request
  input  wire        AVS_WRITE,        // Write request
  input  wire [31:0] AVS_WRITEDATA,    // Write data
  output reg  [31:0] AVS_READDATA,     // Read data
  output wire        AVS_WAITREQUEST   // Stall, active high
);

  // ---------------------------------------------------------------------------
  // Protocol states
  // ---------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_INDEX = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;
  localparam [2:0] ST_SKIP = 3'h5;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  reg [2:0] scl_sync_reg, sda_sync_reg, en_sync_reg, sel_sync_reg, uv_sync_reg;
  reg       scl_reg, sda_reg, en_reg, sel_reg, uv_reg;

  // Idle levels on reset keep a false START or edge from following reset
  // A change counts once flops two and three agree
  always @(posedge CLK_SYS) begin
    if (RST) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      en_sync_reg  <= 3'h0;
      sel_sync_reg <= 3'h0;
      uv_sync_reg  <= 3'h0;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
      en_reg       <= 1'b0;
      sel_reg      <= 1'b0;
      uv_reg       <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN};
      en_sync_reg  <= {en_sync_reg[1:0], ENABLE_PIN};
      sel_sync_reg <= {sel_sync_reg[1:0], VOLTAGE_SELECT_PIN};
      uv_sync_reg  <= {uv_sync_reg[1:0], SUPPLY_LOCKOUT};
      if (scl_sync_reg[1] == scl_sync_reg[2]) scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2]) sda_reg <= sda_sync_reg[2];
      if (en_sync_reg[1] == en_sync_reg[2]) en_reg <= en_sync_reg[2];
      if (sel_sync_reg[1] == sel_sync_reg[2]) sel_reg <= sel_sync_reg[2];
      if (uv_sync_reg[1] == uv_sync_reg[2]) uv_reg <= uv_sync_reg[2];
    end
  end

  // ---------------------------------------------------------------------------
  // Bus condition detection
  // ---------------------------------------------------------------------------
  reg  scl_prev_reg, sda_prev_reg;
  wire scl_rise = scl_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_reg & scl_prev_reg;
  // Conditions need SCL high on both samples; data moving under low SCL never counts
  wire start_cond = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
  wire stop_cond  = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
  // Lockout treated like reset for the protocol engine, register file and pull-down outputs
  wire soft_rst = RST | uv_reg;

  always @(posedge CLK_SYS) begin
    if (RST) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------------------
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [2:0] index_reg;
  reg       ack_phase_reg;
  reg       commit_pend_reg;
  reg       first_byte_reg;
  // Eight-entry register file shared by the link and Avalon
  reg [7:0] regs_reg [0:`NUM_REGS-1];
  reg [7:0] tx_reg;
  reg       rd_ack_reg;
  integer   i;

  // Only index 0 reads back over the link; other indices read as zero there
  function [7:0] reg_read;
    input [2:0] idx;
    begin
      reg_read = (idx == `IDX_PULLDOWN) ? regs_reg[idx] : 8'h00;
    end
  endfunction

  // Decodes of the byte just shifted in
  wire [7:0] rx_byte = shift_reg;
  wire       addr_hit = (rx_byte[7:1] == `SLAVE_ADDR);
  wire       is_mcode = (rx_byte[7:3] == `MASTER_CODE_TOP);
  // Avalon write to words 0-7 lands unless a serial commit, START, STOP or soft reset falls in this cycle
  wire       av_reg_wr = AVS_WRITE & ~AVS_ADDRESS[3] & ~AVS_WAITREQUEST;
  wire       serial_commit = commit_pend_reg & scl_fall;
  // Byte handed out on a read, fetched at the end of the acknowledge slot
  wire [7:0] rd_val = reg_read(index_reg);

  // Bit counter starts at 4'hF after a START, so the first SCL fall, which
  // comes before the first data bit, brings it to zero; eight rises later
  // a count of 7 marks the ninth clock, the acknowledge slot.
  // Bits are taken on SCL rise; our own drive changes only after an SCL fall
  // has been seen, about five clocks after the pin moved, which is why the
  // master must hold SCL low longer than that.
  always @(posedge CLK_SYS) begin
    if (soft_rst) begin
      state_reg       <= ST_IDLE;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 8'h00;
      index_reg       <= 3'h0;
      ack_phase_reg   <= 1'b0;
      commit_pend_reg <= 1'b0;
      first_byte_reg  <= 1'b0;
      tx_reg          <= 8'h00;
      SDA_OE          <= 1'b0;
      HS_MODE         <= 1'b0;
      for (i = 0; i < `NUM_REGS; i = i + 1)
        regs_reg[i] <= `REG_DEFAULT;
    end else if (stop_cond) begin
      // STOP ends any transfer and drops high-speed mode
      state_reg <= ST_IDLE;
      SDA_OE    <= 1'b0;
      HS_MODE   <= 1'b0;
      commit_pend_reg <= 1'b0;
    end else if (start_cond) begin
      // START or repeated START: next byte is an address
      state_reg      <= ST_ADDR;
      bit_cnt_reg    <= 4'hF;  // Wraps to zero on the first SCL fall
      ack_phase_reg  <= 1'b0;
      SDA_OE         <= 1'b0;
      first_byte_reg <= ~HS_MODE;
    end else begin
      if (av_reg_wr)
        regs_reg[AVS_ADDRESS[2:0]] <= AVS_WRITEDATA[7:0];
      if (serial_commit) begin
        regs_reg[index_reg] <= shift_reg;
        commit_pend_reg     <= 1'b0;
      end
      if (scl_rise && state_reg != ST_IDLE && !ack_phase_reg)
        shift_reg <= {shift_reg[6:0], sda_reg};
      if (scl_rise && ack_phase_reg && state_reg == ST_RDATA && sda_reg)
        state_reg <= ST_SKIP;  // master NAK ends the read
      if (scl_fall && state_reg != ST_IDLE && state_reg != ST_SKIP) begin
        if (ack_phase_reg) begin
          // Acknowledge slot over: release line, start next byte
          ack_phase_reg <= 1'b0;
          bit_cnt_reg   <= 4'h0;
          SDA_OE        <= 1'b0;
          if (state_reg == ST_RDATA) begin
            tx_reg <= reg_read(index_reg);
            SDA_OE <= ~rd_val[7];  // Pull low for a zero MSB
          end
        end else if (bit_cnt_reg == 4'h7) begin
          ack_phase_reg <= 1'b1;
          bit_cnt_reg   <= 4'h0;
          case (state_reg)
            ST_ADDR: begin
              if (first_byte_reg && is_mcode) begin
                HS_MODE   <= 1'b1;  // no acknowledge
                state_reg <= ST_SKIP;
              end else if (addr_hit) begin
                SDA_OE    <= 1'b1;
                state_reg <= rx_byte[0] ? ST_RDATA : ST_INDEX;
              end else begin
                state_reg <= ST_SKIP;
              end
              first_byte_reg <= 1'b0;
            end
            ST_INDEX: begin
              // Upper five index bits are not checked; they are zero by rule
              index_reg <= rx_byte[2:0];
              SDA_OE    <= 1'b1;
              state_reg <= ST_WDATA;
            end
            ST_WDATA: begin
              SDA_OE          <= 1'b1;
              commit_pend_reg <= 1'b1;  // commit at end of ACK
            end
            ST_RDATA: begin
              SDA_OE <= 1'b0;  // Master drives the acknowledge
            end
            default: state_reg <= ST_SKIP;
          endcase
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (state_reg == ST_RDATA) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            SDA_OE <= ~tx_reg[6];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pin pull-down control
  // ---------------------------------------------------------------------------
  // Bit set disables the pull-down; pin high releases it to save current
  wire en_pd_disable  = regs_reg[`IDX_PULLDOWN][`IDX_PULLDOWN_BIT_EN];
  wire sel_pd_disable = regs_reg[`IDX_PULLDOWN][`IDX_PULLDOWN_BIT_SEL];

  // Registered so the pin drivers see no decode glitches
  always @(posedge CLK_SYS) begin
    if (soft_rst) begin
      ENABLE_PD_ON <= 1'b1;
      SELECT_PD_ON <= 1'b1;
    end else begin
      ENABLE_PD_ON <= ~en_reg & ~en_pd_disable;
      SELECT_PD_ON <= ~sel_reg & ~sel_pd_disable;
    end
  end

  // ---------------------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------------------
  // Writes stall one cycle while a serial commit lands, avoiding a double write;
  // reads stall one cycle so that read data can come from flip-flops
  assign AVS_WAITREQUEST = (AVS_WRITE & serial_commit) | (AVS_READ & ~rd_ack_reg);

  // Read answer flag: high for the one cycle in which registered data stands
  always @(posedge CLK_SYS) begin
    if (RST) begin
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= AVS_READ & ~rd_ack_reg;
    end
  end

  // Read data captured on the stall cycle; unmapped words answer zero
  // Data then stands unchanged through the edge at which the master takes it
  always @(posedge CLK_SYS) begin
    if (RST) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ & ~rd_ack_reg) begin
      if (!AVS_ADDRESS[3]) begin
        AVS_READDATA <= {24'h000000, regs_reg[AVS_ADDRESS[2:0]]};
      end else if (AVS_ADDRESS == `AV_STATUS) begin
        AVS_READDATA <= {24'h000000, ENABLE_PD_ON, SELECT_PD_ON, en_reg, sel_reg,
                         HS_MODE, state_reg};
      end else begin
        AVS_READDATA <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Open-drain data pin
  // ---------------------------------------------------------------------------
  // Drive value is fixed low; only the enable moves, so the pin never drives high
  // and a wired-AND bus cannot see contention from this side
  always @(posedge CLK_SYS) begin
    SDA_OUT <= 1'b0;
  end

endmodule // regulator_i2c_slave_port
`default_nettype wire

/* test/port_monitor.sv */
// Purpose: Pin-level assertions for the regulator serial port
// Assumes: Input filters settle within five clocks
// Notes:   Bound to every port instance
`timescale 1ns/1ps
`default_nettype none
module port_monitor (
  input wire logic        CLK_SYS,            // Clock
  input wire logic        RST,                // Reset
  input wire logic        SUPPLY_LOCKOUT,     // Lockout
  input wire logic        SCL_IN,             // Bus clock
  input wire logic        SDA_IN,             // Bus data
  input wire logic        SDA_OUT,            // Drive value
  input wire logic        SDA_OE,             // Drive enable
  input wire logic        ENABLE_PIN,         // Pin level
  input wire logic        VOLTAGE_SELECT_PIN, // Pin level
  input wire logic        ENABLE_PD_ON,       // Pull-down
  input wire logic        SELECT_PD_ON,       // Pull-down
  input wire logic        HS_MODE,            // High-speed mode
  input wire logic [3:0]  AVS_ADDRESS,        // Word address
  input wire logic        AVS_READ,           // Read strobe
  input wire logic [31:0] AVS_READDATA,       // Read data
  input wire logic        AVS_WAITREQUEST     // Stall
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // ------
  // Checks
  // ------
  reset_state_a: assert property ($past(RST) |->
    !SDA_OE && ENABLE_PD_ON && SELECT_PD_ON && !HS_MODE) else $error("bad reset state");
  out_low_a: assert property (!SDA_OUT) else $error("data drive not low");
  en_release_a: assert property ((ENABLE_PIN && !SUPPLY_LOCKOUT) [*6] |-> !ENABLE_PD_ON)
    else $error("enable pull-down kept");
  sel_release_a: assert property ((VOLTAGE_SELECT_PIN && !SUPPLY_LOCKOUT) [*6] |-> !SELECT_PD_ON)
    else $error("select pull-down kept");
  supply_lockout_a: assert property (SUPPLY_LOCKOUT [*6] |->
    ENABLE_PD_ON && SELECT_PD_ON && !HS_MODE && !SDA_OE) else $error("lockout ignored");
  hs_nak_a: assert property ($rose(HS_MODE) |-> !SDA_OE [*8])
    else $error("master code acked");
  // Release of our own ack is not a stop, so exclude it
  hs_stop_a: assert property ($rose(SDA_IN) && SCL_IN && !$past(SDA_OE) && HS_MODE
    |-> ##[1:8] !HS_MODE) else $error("stop kept fast mode");
  unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 4'h9
    |-> AVS_READDATA == 32'h0)
    else $error("unmapped word not zero");
endmodule // port_monitor
bind regulator_i2c_slave_port port_monitor mon_u (
  .CLK_SYS(CLK_SYS), .RST(RST), .SUPPLY_LOCKOUT(SUPPLY_LOCKOUT), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ENABLE_PIN(ENABLE_PIN),
  .VOLTAGE_SELECT_PIN(VOLTAGE_SELECT_PIN), .ENABLE_PD_ON(ENABLE_PD_ON),
  .SELECT_PD_ON(SELECT_PD_ON), .HS_MODE(HS_MODE), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
`default_nettype wire

/* test/i2c_master_model.sv */
// Purpose: Serial bus master facing the regulator port
// Assumes: Bit cell of eight bench clocks, 800 ns
// Notes:   Clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic clk,    // Bench clock
  input  wire logic sda_oe, // Slave pulls data low
  output var  logic scl,    // Serial clock
  output var  logic sda     // Resolved data line
);
  logic drive_low = 1'b0;
  initial scl = 1'b1;
  // Pull-up wins unless a party pulls low
  always_comb sda = !(drive_low || sda_oe);
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data falls while clock high; doubles as repeated start
  task automatic start();
    scl <= 1'b0;
    w(1);
    drive_low <= 1'b0;
    w(6);
    scl <= 1'b1;
    w(4);
    drive_low <= 1'b1;
    w(4);
  endtask
  // Data rises while clock high
  task automatic stop();
    scl <= 1'b0;
    w(1);
    drive_low <= 1'b1;
    w(6);
    scl <= 1'b1;
    w(4);
    drive_low <= 1'b0;
    w(8);
  endtask
  // Data moves one clock after the fall, to keep hold time; low for six
  // clocks so the slave's filtered drive settles before SCL rises
  task automatic bit_io(input logic b, output logic got);
    scl <= 1'b0;
    w(1);
    drive_low <= !b;
    w(5);
    scl <= 1'b1;
    w(2);
    got = sda;
  endtask
  // Byte out MSB first, then the ninth bit released or NAK
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, ack);
    ack = !ack;
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for the regulator serial port
// Assumes: Slave address 0x60, index 0 holds pull-down disables
// Notes:   Pins held low unless a scenario raises them
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst = 1'b1, lock = 1'b0, en_pin = 1'b0, sel_pin = 1'b0;
  logic        av_rd = 1'b0, av_wr = 1'b0, scl, sda, oe, en_pd, sel_pd, hs, av_wait, nk;
  logic [3:0]  av_addr = 4'h0;
  logic [31:0] av_wd = 32'h0, av_rdata, av_q;
  logic [7:0]  q;
  logic [2:0]  ak;
  int          fails = 0, check_count = 0;
  // Clock
  initial begin
    forever #50 clk = !clk;
  end
  regulator_i2c_slave_port dut_u (.CLK_SYS(clk), .RST(rst), .SUPPLY_LOCKOUT(lock),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(oe), .ENABLE_PIN(en_pin),
    .VOLTAGE_SELECT_PIN(sel_pin), .ENABLE_PD_ON(en_pd), .SELECT_PD_ON(sel_pd), .HS_MODE(hs),
    .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd),
    .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait));
  i2c_master_model m_u (.clk(clk), .sda_oe(oe), .scl(scl), .sda(sda));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %0h got %0h", n, exp, got);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    av_addr <= a;
    av_wd <= d;
    av_wr <= wr;
    av_rd <= !wr;
    // Slave outputs move only on rising edges: the falling-edge level is the sampled one
    @(negedge clk);
    while (av_wait !== 1'b0) begin
      @(negedge clk);
    end
    av_q = av_rdata;
    @(posedge clk);
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] sa, input logic [7:0] idx, input logic [7:0] d);
    m_u.start();
    m_u.xfer(sa, q, ak[2]);
    m_u.xfer(idx, q, ak[1]);
    m_u.xfer(d, q, ak[0]);
    m_u.stop();
  endtask
  task automatic rd(input logic [7:0] idx);
    m_u.start();
    m_u.xfer(8'hC0, q, ak[2]);
    m_u.xfer(idx, q, ak[1]);
    m_u.start();
    m_u.xfer(8'hC1, q, ak[0]);
    m_u.xfer(8'hFF, q, nk);
    m_u.stop();
  endtask
  task automatic t_write_read();
    wr(8'hC0, 8'h00, 8'h01);
    chk("write acks", ak, 3'b111);
    chk("pull-downs", {en_pd, sel_pd}, 2'b01);
    rd(8'h00);
    chk("read acks", ak, 3'b111);
    chk("read back", q, 8'h01);
    av(1'b1, 4'h0, 32'h2);
    chk("pull-downs", {en_pd, sel_pd}, 2'b10);
  endtask
  task automatic t_pins();
    en_pin <= 1'b1;
    sel_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk("pins high", {en_pd, sel_pd}, 2'b00);
    av(1'b0, 4'h8, 32'h0);
    chk("status word", av_q, 32'h30);
    en_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk("enable low", {en_pd, sel_pd}, 2'b10);
    sel_pin <= 1'b0;
  endtask
  task automatic t_bad_addr();
    wr(8'hC2, 8'h00, 8'h00);
    chk("other address", ak, 3'b000);
    chk("kept", {en_pd, sel_pd}, 2'b10);
    wr(8'h00, 8'h00, 8'h00);
    chk("general call", ak, 3'b000);
    wr(8'hC0, 8'h05, 8'hA5);
    rd(8'h05);
    chk("unlisted index", q, 8'h00);
    av(1'b1, 4'hF, 32'hFFFFFFFF);
    av(1'b0, 4'hF, 32'h0);
    chk("unmapped word", av_q, 32'h0);
  endtask
  task automatic t_hs();
    m_u.start();
    m_u.xfer(8'h09, q, ak[2]);
    chk("code nak", ak[2], 1'b0);
    chk("fast on", hs, 1'b1);
    wr(8'hC0, 8'h00, 8'h03);
    chk("fast acks", ak, 3'b111);
    chk("fast off", {hs, en_pd, sel_pd}, 3'b000);
  endtask
  task automatic t_lockout();
    lock <= 1'b1;
    repeat (8) @(posedge clk);
    lock <= 1'b0;
    repeat (8) @(posedge clk);
    chk("lockout", {hs, en_pd, sel_pd}, 3'b011);
    rd(8'h00);
    chk("lockout reg", q, 8'h00);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("reset", {hs, en_pd, sel_pd}, 3'b011);
    t_write_read();
    t_pins();
    t_bad_addr();
    t_hs();
    t_lockout();
    close_out();
  end
  // Watchdog
  initial begin
    #5000000;
    fails++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
